// ---- verilog/dscp_pkg.sv ----
// constants and types shared by the dac serial control core
package dscp_pkg;

  // ****************************************
  // register bus map
  // ****************************************
  localparam int AXI_ADDR_W = 4;
  localparam logic [AXI_ADDR_W-1:0] CTRL_OFFSET = 4'h0;
  localparam logic [AXI_ADDR_W-1:0] STATUS_OFFSET = 4'h4;
  localparam int CTRL_ADDR_HI_LSB = 0;
  localparam int ST_DAC_LSB = 0;
  localparam int ST_IN_LSB = 16;
  localparam int ST_PD_LSB = 28;
  localparam int ST_BUSY_BIT = 31;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // upper six slave address bits after reset; value arbitrary
  localparam logic [5:0] ADDR_HI_RESET = 6'h15;

  // ****************************************
  // converter and serial word layout
  // ****************************************
  localparam int CODE_W = 10;
  localparam logic [CODE_W-1:0] CODE_RESET = 10'h000;
  localparam logic [3:0] BITS_PER_WORD = 4'h8;
  localparam logic [3:0] CMD_LOAD_BOTH = 4'hc;
  localparam logic [3:0] CMD_LOAD_IN = 4'hd;
  localparam logic [3:0] CMD_LOAD_SHIFT = 4'he;
  localparam logic [3:0] CMD_UPDATE = 4'hf;
  localparam logic [1:0] CMD_POWER = 2'h1;
  localparam logic FILT_RESET = 1'h1;

  // power state, coded as the two power-down select bits
  typedef enum logic [1:0] {
    PD_UP = 2'b00,
    PD_FLOAT = 2'b01,
    PD_1K = 2'b10,
    PD_100K = 2'b11
  } dscp_pd_t;
  localparam dscp_pd_t PD_RESET = PD_100K;

  // serial slave states
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_ADDR = 4'b0001,
    S_ADDR_ACK = 4'b0010,
    S_CMD = 4'b0011,
    S_CMD_ACK = 4'b0100,
    S_DATA = 4'b0101,
    S_DATA_ACK = 4'b0110,
    S_RD = 4'b0111,
    S_RD_ACK = 4'b1000
  } dscp_state_t;

endpackage : dscp_pkg

// ---- verilog/dscp_pin_filter.sv ----
// three-stage synchroniser and agreement filter for one pin
`timescale 1ns/1ps
`default_nettype none
module dscp_pin_filter (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic pin, // raw pin level
  output logic level // filtered level
);
  import dscp_pkg::*;

  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic lvl;
  } dscp_filt_t;

  localparam dscp_filt_t FILT_ST_RESET = '{ff1: FILT_RESET, ff2: FILT_RESET, ff3: FILT_RESET, lvl: FILT_RESET};

  dscp_filt_t st_reg;
  dscp_filt_t st_next;

  // ff1 feeds ff2 only; level moves once ff2 and ff3 agree
  always_comb begin
    st_next = st_reg;
    st_next.ff1 = pin;
    st_next.ff2 = st_reg.ff1;
    st_next.ff3 = st_reg.ff2;
    if (st_reg.ff2 == st_reg.ff3) begin
      st_next.lvl = st_reg.ff3;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= FILT_ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.lvl;

endmodule : dscp_pin_filter
`default_nettype wire

// ---- verilog/dscp_core.sv ----
// two-wire slave, data registers and power-down control of the dac
`timescale 1ns/1ps
`default_nettype none
module dscp_core (
  input wire logic aclk, // 10 MHz system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [dscp_pkg::AXI_ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [dscp_pkg::AXI_ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic scl_in, // serial clock pin level
  input wire logic sda_in, // serial data pin level
  output logic sda_o, // serial data drive value
  output logic sda_oe, // high while pulling sda low
  input wire logic addr_sel, // address select pin
  output logic [dscp_pkg::CODE_W-1:0] dac_code, // code to resistor string
  output logic buffer_en, // output buffer enable
  output logic string_en, // resistor string supply enable
  output logic term_1k, // 1k termination to ground
  output logic term_100k // 100k termination to ground
);
  import dscp_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    dscp_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic [3:0] cmd;
    logic [3:0] dhi;
    logic rd_idx;
    logic nack;
    logic oe;
    logic scl_q;
    logic sda_q;
    logic [CODE_W-1:0] in_reg;
    logic [CODE_W-1:0] dac_reg;
    dscp_pd_t pd;
    logic [5:0] addr_hi;
    logic aw_got;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dscp_st_t;

  localparam dscp_st_t ST_RESET = '{state: S_IDLE, pd: PD_RESET, addr_hi: ADDR_HI_RESET,
                                    scl_q: FILT_RESET, sda_q: FILT_RESET, default: '0};

  dscp_st_t st_reg;
  dscp_st_t st_next;

  // ****************************************
  // pin filters
  // ****************************************
  logic [2:0] pin_raw;
  logic [2:0] pin_f;
  logic scl_f;
  logic sda_f;
  logic addr_f;

  assign pin_raw = {addr_sel, sda_in, scl_in};

  // one filter per pin
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      dscp_pin_filter u_filt (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(pin_raw[gi]),
        .level(pin_f[gi])
      );
    end
  endgenerate

  assign scl_f = pin_f[0];
  assign sda_f = pin_f[1];
  assign addr_f = pin_f[2];

  // ****************************************
  // bus conditions
  // ****************************************
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic addr_hit;
  logic [CODE_W-1:0] word_code;
  logic [7:0] rd_byte;

  // sda moving while scl stays high is a condition, never data
  assign start_ev = st_reg.scl_q & scl_f & st_reg.sda_q & ~sda_f;
  assign stop_ev = st_reg.scl_q & scl_f & ~st_reg.sda_q & sda_f;
  assign scl_rise = ~st_reg.scl_q & scl_f;
  assign scl_fall = st_reg.scl_q & ~scl_f;
  // the address lsb follows the select pin
  assign addr_hit = (st_reg.shreg[7:1] == {st_reg.addr_hi, addr_f});
  // first byte carries the top four code bits, second the low six
  assign word_code = {st_reg.dhi, st_reg.shreg[7:2]};
  // read-back always opens with power bits and top of code, whatever an earlier read left in rd_idx
  assign rd_byte = {st_reg.pd, 2'b00, st_reg.dac_reg[9:6]};

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.scl_q = scl_f;
    st_next.sda_q = sda_f;

    // serial slave, stepped by filtered scl edges
    if (start_ev) begin
      st_next.state = S_ADDR;
      st_next.bitcnt = 4'h0;
      st_next.oe = 1'b0;
    end else if (stop_ev) begin
      st_next.state = S_IDLE;
      st_next.oe = 1'b0;
    end else if (scl_rise) begin
      case (st_reg.state)
        S_ADDR, S_CMD, S_DATA: begin
          st_next.shreg = {st_reg.shreg[6:0], sda_f};
          st_next.bitcnt = st_reg.bitcnt + 4'h1;
        end
        S_RD: begin
          st_next.bitcnt = st_reg.bitcnt + 4'h1;
        end
        S_RD_ACK: begin
          st_next.nack = sda_f;
        end
        default: begin
          st_next.bitcnt = st_reg.bitcnt;
        end
      endcase
    end else if (scl_fall) begin
      case (st_reg.state)
        S_ADDR: begin
          if (st_reg.bitcnt == BITS_PER_WORD) begin
            if (addr_hit) begin
              st_next.oe = 1'b1;
              st_next.rw = st_reg.shreg[0];
              st_next.state = S_ADDR_ACK;
            end else begin
              // foreign address: sleep until the next start
              st_next.state = S_IDLE;
            end
          end
        end
        S_ADDR_ACK: begin
          st_next.bitcnt = 4'h0;
          if (st_reg.rw) begin
            st_next.state = S_RD;
            st_next.rd_idx = 1'b0;
            st_next.shreg = rd_byte;
            st_next.oe = ~rd_byte[7];
          end else begin
            st_next.state = S_CMD;
            st_next.oe = 1'b0;
          end
        end
        S_CMD, S_DATA: begin
          if (st_reg.bitcnt == BITS_PER_WORD) begin
            st_next.oe = 1'b1;
            st_next.state = (st_reg.state == S_CMD) ? S_CMD_ACK : S_DATA_ACK;
          end
        end
        S_CMD_ACK: begin
          // commands without a data part act at the end of this acknowledge
          st_next.oe = 1'b0;
          st_next.bitcnt = 4'h0;
          st_next.cmd = st_reg.shreg[7:4];
          st_next.dhi = st_reg.shreg[3:0];
          st_next.state = S_DATA;
          if (st_reg.shreg[7:6] == CMD_POWER) begin
            // dac register untouched, so waking restores the held code
            st_next.pd = dscp_pd_t'(st_reg.shreg[3:2]);
          end else if (st_reg.shreg[7:4] == CMD_UPDATE) begin
            st_next.dac_reg = st_reg.in_reg;
          end
        end
        S_DATA_ACK: begin
          st_next.oe = 1'b0;
          st_next.bitcnt = 4'h0;
          st_next.state = S_CMD;
          // writes land in any power state; only the buffer and the string stay off
          case (st_reg.cmd)
            CMD_LOAD_BOTH: begin
              st_next.in_reg = word_code;
              st_next.dac_reg = word_code;
            end
            CMD_LOAD_IN: begin
              st_next.in_reg = word_code;
            end
            CMD_LOAD_SHIFT: begin
              st_next.dac_reg = st_reg.in_reg;
              st_next.in_reg = word_code;
            end
            default: begin
              st_next.in_reg = st_reg.in_reg;
            end
          endcase
        end
        S_RD: begin
          if (st_reg.bitcnt == BITS_PER_WORD) begin
            st_next.oe = 1'b0;
            st_next.state = S_RD_ACK;
          end else begin
            st_next.shreg = {st_reg.shreg[6:0], 1'b0};
            st_next.oe = ~st_reg.shreg[6];
          end
        end
        S_RD_ACK: begin
          // a nack hands the bus back; the master then stops
          if (st_reg.nack) begin
            st_next.state = S_IDLE;
          end else begin
            st_next.state = S_RD;
            st_next.bitcnt = 4'h0;
            st_next.rd_idx = ~st_reg.rd_idx;
            st_next.shreg = st_reg.rd_idx ? {st_reg.pd, 2'b00, st_reg.dac_reg[9:6]}
                                          : {st_reg.dac_reg[5:0], 2'b00};
            st_next.oe = st_reg.rd_idx ? ~st_reg.pd[1] : ~st_reg.dac_reg[5];
          end
        end
        default: begin
          st_next.oe = 1'b0;
        end
      endcase
    end

    // register bus: write address and data may come in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_got = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.aw_got && st_reg.w_got) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      if (st_reg.aw_addr == CTRL_OFFSET) begin
        if (st_reg.w_strb[0]) begin
          st_next.addr_hi = st_reg.w_data[CTRL_ADDR_HI_LSB +: 6];
        end
      end else if (st_reg.aw_addr != STATUS_OFFSET) begin
        st_next.bresp = RESP_SLVERR;
      end
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = 32'h0000_0000;
      st_next.rresp = RESP_OKAY;
      case (s_axi_araddr)
        CTRL_OFFSET: begin
          st_next.rdata[CTRL_ADDR_HI_LSB +: 6] = st_reg.addr_hi;
        end
        STATUS_OFFSET: begin
          st_next.rdata[ST_DAC_LSB +: CODE_W] = st_reg.dac_reg;
          st_next.rdata[ST_IN_LSB +: CODE_W] = st_reg.in_reg;
          st_next.rdata[ST_PD_LSB +: 2] = st_reg.pd;
          st_next.rdata[ST_BUSY_BIT] = (st_reg.state != S_IDLE);
        end
        default: begin
          st_next.rresp = RESP_SLVERR;
        end
      endcase
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  // registers keep their value until rewritten or reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // bus ready is held off while a response waits, one write at a time
  assign s_axi_awready = ~st_reg.aw_got & ~st_reg.bvalid;
  assign s_axi_wready = ~st_reg.w_got & ~st_reg.bvalid;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = ~st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  // only ever pull low; scl has no driver here at all
  assign sda_o = 1'b0;
  assign sda_oe = st_reg.oe;
  assign dac_code = st_reg.dac_reg;
  // every power-down mode cuts buffer and string; only termination differs
  assign buffer_en = (st_reg.pd == PD_UP);
  assign string_en = (st_reg.pd == PD_UP);
  assign term_1k = (st_reg.pd == PD_1K);
  assign term_100k = (st_reg.pd == PD_100K);

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_sda_low_only: assert property (sda_oe |-> sda_o == 1'b0) else $error("sda driven high");
  a_reset_state: assert property ($past(!aresetn) |-> (st_reg.pd == PD_100K && dac_code == 10'h000
    && st_reg.in_reg == 10'h000 && term_100k && !buffer_en)) else $error("bad reset state");
  a_pd_cuts: assert property (st_reg.pd != PD_UP |-> !buffer_en && !string_en)
    else $error("buffer on in power-down");
  a_term_one: assert property ($onehot0({buffer_en, term_1k, term_100k}) && (term_1k || term_100k ||
    buffer_en || st_reg.pd == PD_FLOAT)) else $error("termination decode wrong");
  a_commit_fall: assert property ($changed(st_reg.dac_reg) |-> $past(scl_fall)
    && ($past(st_reg.state) == S_DATA_ACK || $past(st_reg.state) == S_CMD_ACK))
    else $error("dac register moved off an ack fall");
  a_pd_keeps: assert property ($changed(st_reg.pd) |-> $stable(st_reg.dac_reg) && $stable(st_reg.in_reg))
    else $error("power change altered data");
  a_ack_drive: assert property (scl_fall && st_reg.state == S_CMD && st_reg.bitcnt == BITS_PER_WORD
    |=> sda_oe [*2]) else $error("no acknowledge");
  a_start_addr: assert property (start_ev |=> st_reg.state == S_ADDR && st_reg.bitcnt == 4'h0)
    else $error("start not taken");
  a_stop_idle: assert property (stop_ev && !start_ev |=> st_reg.state == S_IDLE && !sda_oe)
    else $error("stop not taken");
  a_addr_miss: assert property (scl_fall && st_reg.state == S_ADDR && st_reg.bitcnt == BITS_PER_WORD
    && st_reg.shreg[1] != addr_f ##0 !start_ev && !stop_ev |=> !sda_oe)
    else $error("wrong address acknowledged");
  a_load_in_only: assert property (scl_fall && st_reg.state == S_DATA_ACK && st_reg.cmd == CMD_LOAD_IN
    && !start_ev && !stop_ev |=> $stable(dac_code)) else $error("input write moved output");

  c_write_both: cover property (scl_fall && st_reg.state == S_DATA_ACK && st_reg.cmd == CMD_LOAD_BOTH);
  c_power_up: cover property ($past(st_reg.pd) != PD_UP && st_reg.pd == PD_UP);
  c_read_back: cover property (st_reg.state == S_RD_ACK ##1 st_reg.state == S_RD);
  c_axi_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);

endmodule : dscp_core
`default_nettype wire

// ---- testbench/dscp_bus_master.sv ----
// behavioural two-wire bus master that drives the dac core's serial pins
`timescale 1ns/1ps
`default_nettype none
module dscp_bus_master (
  input wire logic aclk, // system clock that paces the bus
  input wire logic sda, // resolved sda wire level
  output logic scl, // serial clock, made here only
  output logic sda_low // high while pulling sda low
);
  // ****************************************
  // idle state
  // ****************************************
  // both lines released; scl stands still between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // ****************************************
  // bit and frame tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  // 8 aclk per bit; the long low phase leaves the slave room for its filter lag
  task automatic bit_io(input logic o, output logic i);
    tick(1);
    sda_low <= !o;
    tick(5);
    scl <= 1'b1;
    tick(2);
    i = sda;
    scl <= 1'b0;
  endtask : bit_io

  // sda falls while scl high
  task automatic start();
    tick(1);
    sda_low <= 1'b0;
    tick(5);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask : start

  // sda rises while scl high, then the bus rests released
  task automatic stop();
    tick(1);
    sda_low <= 1'b1;
    tick(5);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(4);
  endtask : stop

  // eight bits msb first, then the acknowledge clock
  task automatic wbyte(input logic [7:0] b, output logic nack);
    logic x;
    for (int k = 7; k >= 0; k--) bit_io(b[k], x);
    bit_io(1'b1, nack);
  endtask : wbyte

  task automatic rbyte(output logic [7:0] b, input logic last);
    logic x;
    for (int k = 7; k >= 0; k--) bit_io(1'b1, b[k]);
    bit_io(last, x);
  endtask : rbyte
endmodule : dscp_bus_master
`default_nettype wire

// ---- testbench/dscp_core_bench.sv ----
// self-checking bench: register bus and two-wire traffic into the dac core
`timescale 1ns/1ps
`default_nettype none
module dscp_core_bench;
  import dscp_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic aclk;
  logic aresetn = 1'b0;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr = '0;
  logic [AXI_ADDR_W-1:0] s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, addr_sel = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic sda_o, sda_oe, buffer_en, string_en, term_1k, term_100k, scl, m_low, sda_w;
  logic [CODE_W-1:0] dac_code;
  logic [5:0] addr_hi = ADDR_HI_RESET;
  logic [6:0] tgt = {ADDR_HI_RESET, 1'b0};
  int n_errors = 0;
  int checks_done = 0;

  // open-drain wire: anyone pulling wins, else the pull-up holds it high
  assign sda_w = m_low ? 1'b0 : (sda_oe ? sda_o : 1'b1);

  dscp_core dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .scl_in(scl), .sda_in(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .addr_sel(addr_sel), .dac_code(dac_code), .buffer_en(buffer_en),
    .string_en(string_en), .term_1k(term_1k), .term_100k(term_100k));
  dscp_bus_master m (.aclk(aclk), .sda(sda_w), .scl(scl), .sda_low(m_low));

  // ****************************************
  // access tasks
  // ****************************************
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [AXI_ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [AXI_ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // status word, converter code and output switches against one expected state
  task automatic chk_st(input logic [9:0] dv, input logic [9:0] iv, input dscp_pd_t pd);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(STATUS_OFFSET, d, r);
    chk({r, d}, {RESP_OKAY, 2'b00, pd, 2'b00, iv, 6'h00, dv});
    chk({24'h0, dac_code}, {24'h0, dv});
    chk({30'h0, buffer_en, string_en, term_1k, term_100k},
      {30'h0, pd == PD_UP, pd == PD_UP, pd == PD_1K, pd == PD_100K});
  endtask : chk_st

  // one write frame; a wrong address must get no acknowledge at all
  task automatic frame(input logic [3:0] cmd, input logic [9:0] code, input int n);
    logic nk;
    logic miss;
    m.start();
    miss = (tgt != {addr_hi, addr_sel});
    m.wbyte({tgt, 1'b0}, nk);
    chk(nk, miss);
    m.wbyte({cmd, code[9:6]}, nk);
    chk(nk, miss);
    if (n > 1) begin
      m.wbyte({code[5:0], 2'b00}, nk);
      chk(nk, miss);
    end
    m.stop();
  endtask : frame

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  // ****************************************
  // clock, watchdog and tests
  // ****************************************
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // whole run is some 2800 cycles; far beyond that means a hang
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    wrap_up();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] b0, b1;
    logic nk;
    dscp_pd_t md [4] = '{PD_FLOAT, PD_1K, PD_100K, PD_UP};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    chk_st(10'h000, 10'h000, PD_100K);
    axi_rd(CTRL_OFFSET, d, r);
    chk({r, d}, {RESP_OKAY, 26'h0, ADDR_HI_RESET});
    axi_rd(4'h8, d, r);
    chk({r, d}, {RESP_SLVERR, 32'h0});
    axi_wr(4'hc, 32'h1, r);
    chk(r, RESP_SLVERR);
    axi_wr(STATUS_OFFSET, 32'hffffffff, r);
    chk(r, RESP_OKAY);
    chk_st(10'h000, 10'h000, PD_100K);
    frame(CMD_LOAD_BOTH, 10'h3ff, 2);
    chk_st(10'h3ff, 10'h3ff, PD_100K);
    // every mode in turn, ending powered up before any output is expected
    foreach (md[k]) begin
      frame({CMD_POWER, 2'b00}, {md[k], 8'h00}, 1);
      chk_st(10'h3ff, 10'h3ff, md[k]);
    end
    frame(CMD_LOAD_IN, 10'h155, 2);
    chk_st(10'h3ff, 10'h155, PD_UP);
    frame(CMD_UPDATE, 10'h000, 1);
    chk_st(10'h155, 10'h155, PD_UP);
    frame(CMD_LOAD_SHIFT, 10'h000, 2);
    chk_st(10'h155, 10'h000, PD_UP);
    frame(CMD_LOAD_BOTH, 10'h3ff, 1);
    chk_st(10'h155, 10'h000, PD_UP);
    // read request command: both data registers stay untouched
    frame(4'h8, 10'h2aa, 2);
    chk_st(10'h155, 10'h000, PD_UP);
    m.start();
    m.wbyte({tgt, 1'b1}, nk);
    chk(nk, 1'b0);
    m.rbyte(b0, 1'b0);
    m.rbyte(b1, 1'b1);
    m.stop();
    chk({b0, b1}, {PD_UP, 2'b00, 4'h5, 6'h15, 2'b00});
    addr_sel <= 1'b1;
    frame(CMD_LOAD_BOTH, 10'h001, 2);
    chk_st(10'h155, 10'h000, PD_UP);
    axi_wr(CTRL_OFFSET, 32'h2a, r);
    chk(r, RESP_OKAY);
    addr_hi = 6'h2a;
    tgt = {6'h2a, 1'b1};
    frame(CMD_LOAD_BOTH, 10'h001, 2);
    chk_st(10'h001, 10'h001, PD_UP);
    chk(sda_o, 1'b0);
    wrap_up();
  end
endmodule : dscp_core_bench
`default_nettype wire
